// [rtl/ctc_pkg.sv]
// Shared constants for the counter-timer control block.
// Assumes one 50 MHz clock and a byte-addressed word register port.
package ctc_pkg;
   // Register byte offsets
   localparam logic [7:0] CTC_OFF_CTRL = 8'h00;
   localparam logic [7:0] CTC_OFF_CLKEV = 8'h04;
   localparam logic [7:0] CTC_OFF_RELOAD = 8'h08;
   localparam logic [7:0] CTC_OFF_COUNT = 8'h0c;
   localparam logic [7:0] CTC_OFF_IRQ_ST = 8'h10;
   localparam logic [7:0] CTC_OFF_IRQ_MASK = 8'h14;
   // Control register bit positions
   localparam int CTC_B_ENABLE = 0;
   localparam int CTC_B_RESET = 1;
   localparam int CTC_B_MODE = 2;
   localparam int CTC_B_INPUT_PIN_POLARITY = 4;
   localparam int CTC_B_DIR = 5;
   localparam int CTC_B_OUT_EN = 6;
   localparam int CTC_B_RWRAP = 7;
   localparam int CTC_B_FBYP = 8;
   localparam int CTC_B_PD = 9;
   localparam int CTC_B_OUT_POL = 10;
   localparam int CTC_B_SLEEP = 11;
   localparam int CTC_B_CLK_REQ = 12;
   // Clock and event control bit positions
   localparam int CTC_B_COUNTER_CLOCK_SELECT = 0;
   localparam int CTC_B_EDGE = 5;
   localparam int CTC_B_EVSEL = 7;
   localparam int CTC_B_FCLK = 8;
   // Interrupt status bits
   localparam int CTC_I_WRAP = 0;
   localparam int CTC_I_MEAS = 1;
   // Reset values and counter limits
   localparam logic CTC_PD_RST = 1'b1;
   localparam logic [15:0] CTC_CNT_RST = 16'h0000;
   localparam logic [15:0] CTC_CNT_MAX = 16'hffff;
   localparam logic [15:0] CTC_CNT_MIN = 16'h0000;
   // Edge select codes
   localparam logic [1:0] CTC_EDGE_FALL = 2'h0;
   localparam logic [1:0] CTC_EDGE_RISE = 2'h1;
   localparam logic [1:0] CTC_EDGE_BOTH = 2'h2;
   localparam logic [1:0] CTC_EDGE_NONE = 2'h3;
   // Operating modes in register encoding order
   typedef enum logic [1:0] {
      CTC_MODE_TIMER,
      CTC_MODE_EVENT,
      CTC_MODE_ONESHOT,
      CTC_MODE_MEAS
   } ctc_mode_e;
endpackage

// [rtl/ctc_prescale.sv]
// Power-of-two prescaler giving a one-cycle tick enable.
// Assumes sel_i is steady from a register on the same clock.
`timescale 1ns/1ps
module ctc_prescale #(
   parameter int W = 17
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [3:0] sel_i,
   output logic tick_o
);
   logic [W-1:0] div_r;
   logic [W-1:0] mask;

   // Period is 2^(sel+1) clocks
   assign mask = W'((2 << sel_i) - 1);

   // Divider stops while gated so power-down really freezes it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_r <= '0;
      end else if (run_i) begin
         div_r <= div_r + W'(1);
      end
   end

   // Tick when all selected low bits are ones
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= run_i && ((div_r & mask) == mask);
      end
   end
endmodule

// [rtl/ctc_top.sv]
// Counter-timer control: control registers, 16-bit counter, pin logic.
// Assumes a single-cycle register port master on clk_i, pins async.
//
// Operation
// - Bit 12 reads main clock request
// - Bit 11 reads sleep permission input
// - Bit 10 sets output pin polarity
// - Bit 9 powers down; resets to one
// - Bit 8 bypasses input noise filter
// - Bit 7 reloads on wrap, else rolls (timer and event modes)
// - Bit 6 enables output pin function
// - Event mode: direction bit picks up/down
// - Timer mode: direction bit enables pin pause
// - Input polarity bit inverts input pin
// - Bits 3:2 select the operating mode
// - Bit 1 stops, reloads, clears enable
// - Interrupts blocked once reset clears enable
// - Bit 0 starts/stops; clears pulse output
// - One-shot end clears enable by itself
// - Completed reset cycle clears enable
// - Clock select field picks counter clock
`timescale 1ns/1ps
module ctc_top
   import ctc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic timer_input_pin_i,
   input wire logic sleep_enable_i,
   input wire logic prev_overflow_i,
   output logic timer_output_pin_o,
   output logic main_clock_request_o,
   output logic irq_o
);
   ctc_mode_e mode_r;
   logic enable_r, rst_pend_r, output_pin_polarity_r, power_down_r;
   logic filter_bypass_r, reload_on_wrap_r, output_pin_enable_r;
   logic count_direction_r, input_pin_polarity_r, event_select_r;
   logic [1:0] edge_select_r;
   logic [3:0] counter_clock_select_r, filter_clock_select_r;
   logic [15:0] count_r, reload_r, count_nxt, cap_val;
   logic [1:0] irq_st_r, irq_mask_r;
   logic tin_m_r, tin_s_r, slp_m_r, slp_s_r, filt_r, tin_q_r;
   logic [2:0] filt_sh_r;
   logic armed_r, started_r, out_act_r, out_act_nxt;
   logic tick, ftick, tin_act, rise, fall, edge_hit;
   logic en_clr, ev_wrap, ev_meas, cap, arm_set, go;
   logic wr_ctrl, wr_clkev;

   assign wr_ctrl = wr_i && (addr_i == CTC_OFF_CTRL);
   assign wr_clkev = wr_i && (addr_i == CTC_OFF_CLKEV);

   ////////////////////////////////////////////////////////////////////
   // Counter and filter clock enables
   ctc_prescale #(.W(17)) u_counter_clock_select (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(!power_down_r),
      .sel_i(counter_clock_select_r),
      .tick_o(tick)
   );

   ctc_prescale #(.W(17)) u_fclk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(!power_down_r),
      .sel_i(filter_clock_select_r),
      .tick_o(ftick)
   );

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tin_m_r <= 1'b0;
         tin_s_r <= 1'b0;
         slp_m_r <= 1'b0;
         slp_s_r <= 1'b0;
      end else begin
         tin_m_r <= timer_input_pin_i;
         tin_s_r <= tin_m_r;
         slp_m_r <= sleep_enable_i;
         slp_s_r <= slp_m_r;
      end
   end

   // Noise filter: output follows after three equal filter samples
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         filt_sh_r <= 3'h0;
         filt_r <= 1'b0;
      end else if (ftick) begin
         filt_sh_r <= {filt_sh_r[1:0], tin_s_r};
         if (&filt_sh_r) begin
            filt_r <= 1'b1;
         end else if (~|filt_sh_r) begin
            filt_r <= 1'b0;
         end
      end
   end

   // Effective input level and edges
   assign tin_act = (filter_bypass_r ? tin_s_r : filt_r) ^ input_pin_polarity_r;
   assign rise = tin_act && !tin_q_r;
   assign fall = !tin_act && tin_q_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tin_q_r <= 1'b0;
      end else begin
         tin_q_r <= tin_act;
      end
   end

   always_comb begin
      unique case (edge_select_r)
         CTC_EDGE_FALL: edge_hit = fall;
         CTC_EDGE_RISE: edge_hit = rise;
         CTC_EDGE_BOTH: edge_hit = rise || fall;
         CTC_EDGE_NONE: edge_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Counter next state; nothing runs while reset pends or powered down,
   // so no event can be raised once reset has taken effect
   always_comb begin
      count_nxt = count_r;
      out_act_nxt = out_act_r;
      cap_val = count_r;
      en_clr = 1'b0;
      ev_wrap = 1'b0;
      ev_meas = 1'b0;
      cap = 1'b0;
      arm_set = 1'b0;
      go = 1'b0;
      if (rst_pend_r) begin
         out_act_nxt = 1'b0;
         if (tick) begin
            count_nxt = reload_r;
            en_clr = 1'b1;
         end
      end else if (!enable_r || power_down_r) begin
         out_act_nxt = 1'b0;
      end else begin
         unique case (mode_r)
            CTC_MODE_TIMER: begin
               if (tick && !(count_direction_r && !tin_act)) begin
                  if (count_r == CTC_CNT_MIN) begin
                     ev_wrap = 1'b1;
                     out_act_nxt = !out_act_r;
                     count_nxt = reload_on_wrap_r ? reload_r : CTC_CNT_MAX;
                  end else begin
                     count_nxt = count_r - 16'h0001;
                  end
               end
            end
            CTC_MODE_EVENT: begin
               if (event_select_r ? edge_hit : prev_overflow_i) begin
                  if (count_direction_r) begin
                     if (count_r == CTC_CNT_MAX) begin
                        ev_wrap = 1'b1;
                        out_act_nxt = !out_act_r;
                        count_nxt = reload_on_wrap_r ? reload_r : CTC_CNT_MIN;
                     end else begin
                        count_nxt = count_r + 16'h0001;
                     end
                  end else if (count_r == CTC_CNT_MIN) begin
                     ev_wrap = 1'b1;
                     out_act_nxt = !out_act_r;
                     count_nxt = reload_on_wrap_r ? reload_r : CTC_CNT_MAX;
                  end else begin
                     count_nxt = count_r - 16'h0001;
                  end
               end
            end
            CTC_MODE_ONESHOT: begin
               // Reload setting has no say here: the shot simply ends
               go = started_r || (edge_select_r == CTC_EDGE_NONE) || edge_hit;
               out_act_nxt = go;
               if (go && tick) begin
                  if (count_r == CTC_CNT_MIN) begin
                     ev_wrap = 1'b1;
                     en_clr = 1'b1;
                     out_act_nxt = 1'b0;
                  end else begin
                     count_nxt = count_r - 16'h0001;
                  end
               end
            end
            CTC_MODE_MEAS: begin
               if (edge_hit) begin
                  cap = armed_r;
                  ev_meas = armed_r;
                  arm_set = 1'b1;
                  count_nxt = CTC_CNT_MIN;
               end else if (tick && armed_r) begin
                  if (count_r == CTC_CNT_MAX) begin
                     ev_wrap = 1'b1;
                     en_clr = 1'b1;
                     cap = 1'b1;
                     cap_val = CTC_CNT_MIN;
                     count_nxt = CTC_CNT_MIN;
                  end else begin
                     count_nxt = count_r + 16'h0001;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Counter, reload and sequencing flags
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_r <= CTC_CNT_RST;
      end else begin
         count_r <= count_nxt;
      end
   end

   // Reload is read-only to software while measuring
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reload_r <= CTC_CNT_RST;
      end else if (cap) begin
         reload_r <= cap_val;
      end else if (wr_i && addr_i == CTC_OFF_RELOAD && mode_r != CTC_MODE_MEAS) begin
         reload_r <= wdata_i[15:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         armed_r <= 1'b0;
         started_r <= 1'b0;
         out_act_r <= 1'b0;
      end else begin
         armed_r <= enable_r && !rst_pend_r && (armed_r || arm_set);
         started_r <= enable_r && !rst_pend_r && !en_clr && go;
         out_act_r <= out_act_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control register; a software write of enable beats a hardware clear
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         enable_r <= 1'b0;
      end else if (wr_ctrl) begin
         enable_r <= wdata_i[CTC_B_ENABLE];
      end else if (en_clr) begin
         enable_r <= 1'b0;
      end
   end

   // Reset request holds until the next counter clock completes it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rst_pend_r <= 1'b0;
      end else if (wr_ctrl && wdata_i[CTC_B_RESET]) begin
         rst_pend_r <= 1'b1;
      end else if (rst_pend_r && tick) begin
         rst_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         output_pin_polarity_r <= 1'b0;
         power_down_r <= CTC_PD_RST;
         filter_bypass_r <= 1'b0;
         reload_on_wrap_r <= 1'b0;
         output_pin_enable_r <= 1'b0;
         count_direction_r <= 1'b0;
         input_pin_polarity_r <= 1'b0;
         mode_r <= CTC_MODE_TIMER;
      end else if (wr_ctrl) begin
         output_pin_polarity_r <= wdata_i[CTC_B_OUT_POL];
         power_down_r <= wdata_i[CTC_B_PD];
         filter_bypass_r <= wdata_i[CTC_B_FBYP];
         reload_on_wrap_r <= wdata_i[CTC_B_RWRAP];
         output_pin_enable_r <= wdata_i[CTC_B_OUT_EN];
         count_direction_r <= wdata_i[CTC_B_DIR];
         input_pin_polarity_r <= wdata_i[CTC_B_INPUT_PIN_POLARITY];
         mode_r <= ctc_mode_e'(wdata_i[CTC_B_MODE +: 2]);
      end
   end

   // Clock and event control
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         counter_clock_select_r <= 4'h0;
         filter_clock_select_r <= 4'h0;
         event_select_r <= 1'b0;
         edge_select_r <= CTC_EDGE_FALL;
      end else if (wr_clkev) begin
         counter_clock_select_r <= wdata_i[CTC_B_COUNTER_CLOCK_SELECT +: 4];
         filter_clock_select_r <= wdata_i[CTC_B_FCLK +: 4];
         event_select_r <= wdata_i[CTC_B_EVSEL];
         edge_select_r <= wdata_i[CTC_B_EDGE +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt status (write one to clear, set wins) and mask
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_st_r <= 2'h0;
      end else begin
         irq_st_r <= (irq_st_r & ~((wr_i && addr_i == CTC_OFF_IRQ_ST) ? wdata_i[1:0] : 2'h0))
                     | {ev_meas, ev_wrap};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_mask_r <= 2'h0;
      end else if (wr_i && addr_i == CTC_OFF_IRQ_MASK) begin
         irq_mask_r <= wdata_i[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Registered outputs; idle output level equals the polarity bit
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         timer_output_pin_o <= 1'b0;
         main_clock_request_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         timer_output_pin_o <= output_pin_enable_r ? (out_act_r ^ output_pin_polarity_r)
                                                   : output_pin_polarity_r;
         main_clock_request_o <= !power_down_r && (enable_r || rst_pend_r);
         irq_o <= |(irq_st_r & irq_mask_r);
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0;
      end else if (!rd_i) begin
         rdata_o <= 32'h0;
      end else begin
         unique case (addr_i)
            CTC_OFF_CTRL: rdata_o <= {19'h0, main_clock_request_o, slp_s_r,
               output_pin_polarity_r, power_down_r, filter_bypass_r, reload_on_wrap_r,
               output_pin_enable_r, count_direction_r, input_pin_polarity_r,
               mode_r, rst_pend_r, enable_r};
            CTC_OFF_CLKEV: rdata_o <= {20'h0, filter_clock_select_r, event_select_r,
               edge_select_r, 1'b0, counter_clock_select_r};
            CTC_OFF_RELOAD: rdata_o <= {16'h0, reload_r};
            CTC_OFF_COUNT: rdata_o <= {16'h0, count_r};
            CTC_OFF_IRQ_ST: rdata_o <= {30'h0, irq_st_r};
            CTC_OFF_IRQ_MASK: rdata_o <= {30'h0, irq_mask_r};
            default: rdata_o <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_rd_ctrl;
      rd_i && addr_i == CTC_OFF_CTRL;
   endsequence

   sequence s_reset_req;
      wr_ctrl && wdata_i[CTC_B_RESET];
   endsequence

   property p_clk_req;
      s_rd_ctrl |=> rdata_o[CTC_B_CLK_REQ] == $past(main_clock_request_o);
   endproperty
   a_clk_req: assert property (p_clk_req) else $error("clock request bit wrong");

   property p_sleep;
      s_rd_ctrl |=> rdata_o[CTC_B_SLEEP] == $past(slp_s_r);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep bit wrong");

   property p_reserved;
      s_rd_ctrl |=> rdata_o[31:13] == 19'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");

   property p_pd;
      power_down_r |=> !main_clock_request_o && !tick;
   endproperty
   a_pd: assert property (p_pd) else $error("runs while powered down");

   property p_out_idle;
      !output_pin_enable_r [*2] |-> timer_output_pin_o == $past(output_pin_polarity_r);
   endproperty
   a_out_idle: assert property (p_out_idle) else $error("output pin not idle");

   property p_reset_seq;
      s_reset_req ##1 (rst_pend_r && tick && !wr_ctrl)
         |=> !rst_pend_r && !enable_r && count_r == $past(reload_r);
   endproperty
   a_reset_seq: assert property (p_reset_seq) else $error("reset cycle wrong");

   property p_oneshot_end;
      mode_r == CTC_MODE_ONESHOT && enable_r && !rst_pend_r && !power_down_r && go
         && tick && count_r == CTC_CNT_MIN && !wr_ctrl |=> !enable_r;
   endproperty
   a_oneshot_end: assert property (p_oneshot_end) else $error("one-shot kept enable");

   property p_pulse_clr;
      !enable_r |=> !out_act_r;
   endproperty
   a_pulse_clr: assert property (p_pulse_clr) else $error("pulse kept while off");

   property p_roll;
      mode_r == CTC_MODE_TIMER && enable_r && !rst_pend_r && !power_down_r && tick
         && !reload_on_wrap_r && !count_direction_r && count_r == CTC_CNT_MIN
         |=> count_r == CTC_CNT_MAX;
   endproperty
   a_roll: assert property (p_roll) else $error("timer did not roll over");

   property p_pause;
      mode_r == CTC_MODE_TIMER && enable_r && !rst_pend_r && count_direction_r
         && !tin_act |=> $stable(count_r);
   endproperty
   a_pause: assert property (p_pause) else $error("timer ran while paused");

   property p_no_irq;
      rst_pend_r || !enable_r |=> (irq_st_r & ~$past(irq_st_r)) == 2'h0;
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("event while stopped");
endmodule

// [verif/ctc_pin_src.sv]
// Behavioural source driving the timer input pin.
// Assumes start_i is a one-cycle request on the bench clock.
`timescale 1ns/1ps
module ctc_pin_src (
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [3:0] count_i,
   input wire logic [3:0] half_i,
   input wire logic idle_i,
   output logic pin_o,
   output logic busy_o
);
   int n;
   // Bursts of count_i pulses, half_i cycles per phase; idle level between bursts
   initial begin
      pin_o = 1'b0;
      busy_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (start_i) begin
            busy_o <= 1'b1;
            for (n = 0; n < count_i; n++) begin
               pin_o <= ~idle_i;
               repeat (half_i) @(posedge clk_i);
               pin_o <= idle_i;
               repeat (half_i) @(posedge clk_i);
            end
            busy_o <= 1'b0;
         end else begin
            pin_o <= idle_i;
         end
      end
   end
endmodule

// [verif/tb_ctc_top.sv]
// Self-checking bench for the counter-timer control block.
// Assumes the pin source model; read data are checked by a monitor.
`timescale 1ns/1ps
module tb_ctc_top;
   import ctc_pkg::*;
   logic clk_i, rst_i, wr_i, rd_i, rd_seen, sleep_i, prev_i, tout, creq, irq;
   logic start, idle, busy, pin;
   logic [3:0] cnt, half;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o, v, w, mw, seed;
   logic [31:0] exp_q[$], msk_q[$];
   int n_fail, checks_done, i, k;
   ctc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_input_pin_i(pin),
      .sleep_enable_i(sleep_i), .prev_overflow_i(prev_i), .timer_output_pin_o(tout),
      .main_clock_request_o(creq), .irq_o(irq));
   ctc_pin_src SRC (.clk_i(clk_i), .start_i(start), .count_i(cnt), .half_i(half),
      .idle_i(idle), .pin_o(pin), .busy_o(busy));
   // 50 MHz clock
   always #10 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ev);
      checks_done++;
      if (seen !== ev) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, ev, seen);
      end
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Expectation is noted as the read goes out; a zero mask marks a poll
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      v = rdata_o;
   endtask
   // Poll the self-clearing bit, bounded so a stuck bit cannot hang the run
   task automatic treset(input logic [31:0] b, input logic [15:0] rl);
      wr(CTC_OFF_CTRL, b | 32'h2);
      k = 0;
      do begin
         rd(CTC_OFF_CTRL, 32'h0, 32'h0);
         k++;
      end while (v[1] && k < 40);
      rd(CTC_OFF_CTRL, (b & 32'h7fc) | 32'h800, '1);
      rd(CTC_OFF_COUNT, {16'h0, rl}, '1);
   endtask
   task automatic pulses(input logic [3:0] n, input logic [3:0] h);
      cnt <= n;
      half <= h;
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (k = 0; k < 300 && busy === 1'b1; k++) @(posedge clk_i);
      repeat (8) @(posedge clk_i);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the strobe
   always @(posedge clk_i) rd_seen <= rd_i;
   always @(negedge clk_i) begin
      if (rd_seen === 1'b1) begin
         mw = msk_q.pop_front();
         if (mw != 0) begin
            chk("rdata", rdata_o & mw, exp_q[0]);
         end
         void'(exp_q.pop_front());
      end
   end
   // Run takes under 1000 cycles; twenty times that means a hang
   initial begin
      #400000;
      n_fail++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      addr_i = '0;
      wdata_i = '0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      sleep_i = 1'b1;
      prev_i = 1'b0;
      start = 1'b0;
      cnt = '0;
      half = 4'h3;
      idle = 1'b0;
      seed = 32'h5a;
      n_fail = 0;
      checks_done = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      // Defaults, unmapped space and the sleep mirror
      rd(CTC_OFF_CTRL, 32'h0a00, '1);
      chk("out pin", tout, 32'h0);
      chk("clk req", creq, 32'h0);
      wr(8'h18, 32'hffff_ffff);
      rd(8'h18, 32'h0, '1);
      @(posedge clk_i);
      sleep_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(CTC_OFF_CTRL, 32'h0200, '1);
      @(posedge clk_i);
      sleep_i <= 1'b1;
      $display("test defaults done");
      // Random field values in every mode, kept powered down
      for (i = 0; i < 8; i++) begin
         w = xs();
         w[3:2] = i[1:0];
         w[9] = 1'b1;
         w[1:0] = 2'h0;
         @(posedge clk_i);
         prev_i <= w[31];
         wr(CTC_OFF_CTRL, w);
         rd(CTC_OFF_CTRL, (w & 32'h7fc) | 32'h800, '1);
         chk("idle pin", tout, {31'h0, w[10]});
      end
      $display("test fields done");
      // Timer wrap with and without reload, interrupt masking
      wr(CTC_OFF_CLKEV, 32'h0);
      // Leave measurement mode first, reload is read-only there
      wr(CTC_OFF_CTRL, 32'h200);
      wr(CTC_OFF_RELOAD, 32'h3);
      wr(CTC_OFF_IRQ_MASK, 32'h1);
      treset(32'h0c1, 16'h3);
      wr(CTC_OFF_IRQ_ST, 32'h3);
      wr(CTC_OFF_CTRL, 32'h0c1);
      rd(CTC_OFF_CTRL, 32'h18c1, '1);
      chk("clk req", creq, 32'h1);
      repeat (40) @(posedge clk_i);
      chk("irq", irq, 32'h1);
      rd(CTC_OFF_IRQ_ST, 32'h1, 32'h1);
      rd(CTC_OFF_COUNT, 32'h0, 32'h0);
      chk("reload range", {31'h0, v <= 32'h3}, 32'h1);
      wr(CTC_OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("masked irq", irq, 32'h0);
      wr(CTC_OFF_CTRL, 32'h041);
      repeat (30) @(posedge clk_i);
      rd(CTC_OFF_COUNT, 32'h0, 32'h0);
      chk("rolled", {31'h0, v > 32'h100}, 32'h1);
      wr(CTC_OFF_CTRL, 32'h040);
      wr(CTC_OFF_IRQ_ST, 32'h1);
      wr(CTC_OFF_IRQ_MASK, 32'h1);
      chk("pulse out", tout, 32'h0);
      rd(CTC_OFF_IRQ_ST, 32'h0, '1);
      chk("irq clear", irq, 32'h0);
      $display("test timer done");
      // Stopped count holds; idle input pin pauses the timer
      treset(32'h020, 16'h3);
      repeat (20) @(posedge clk_i);
      rd(CTC_OFF_COUNT, 32'h3, '1);
      wr(CTC_OFF_CTRL, 32'h021);
      repeat (30) @(posedge clk_i);
      rd(CTC_OFF_COUNT, 32'h3, '1);
      wr(CTC_OFF_CTRL, 32'h001);
      repeat (30) @(posedge clk_i);
      rd(CTC_OFF_COUNT, 32'h0, 32'h0);
      chk("runs", {31'h0, v != 32'h3}, 32'h1);
      $display("test pause done");
      // Event counting from the pin, both directions, input polarity edge
      wr(CTC_OFF_RELOAD, 32'h0);
      wr(CTC_OFF_CLKEV, 32'h0a0);
      treset(32'h124, 16'h0);
      wr(CTC_OFF_CTRL, 32'h125);
      pulses(4'h5, 4'h3);
      rd(CTC_OFF_COUNT, 32'h5, '1);
      wr(CTC_OFF_CTRL, 32'h135);
      repeat (6) @(posedge clk_i);
      wr(CTC_OFF_CTRL, 32'h125);
      repeat (6) @(posedge clk_i);
      rd(CTC_OFF_COUNT, 32'h6, '1);
      treset(32'h104, 16'h0);
      wr(CTC_OFF_CTRL, 32'h105);
      pulses(4'h3, 4'h5);
      rd(CTC_OFF_COUNT, 32'hfffd, '1);
      $display("test event done");
      // One-shot with active-low pulse, enable clears itself
      wr(CTC_OFF_CLKEV, 32'h060);
      wr(CTC_OFF_RELOAD, 32'h20);
      treset(32'h448, 16'h20);
      chk("idle high", tout, 32'h1);
      // Clear the wrap left by the event test so the shot must set it again
      wr(CTC_OFF_IRQ_ST, 32'h1);
      wr(CTC_OFF_CTRL, 32'h449);
      repeat (10) @(posedge clk_i);
      chk("pulse low", tout, 32'h0);
      repeat (120) @(posedge clk_i);
      rd(CTC_OFF_CTRL, 32'hc48, '1);
      chk("pulse end", tout, 32'h1);
      rd(CTC_OFF_IRQ_ST, 32'h1, 32'h1);
      $display("test one-shot done");
      // Measurement: first rising edge arms, later ones capture the tick count
      wr(CTC_OFF_CLKEV, 32'h0a0);
      treset(32'h10c, 16'h20);
      wr(CTC_OFF_IRQ_ST, 32'h3);
      wr(CTC_OFF_CTRL, 32'h10d);
      pulses(4'h3, 4'h4);
      rd(CTC_OFF_RELOAD, 32'h0, 32'h0);
      chk("period", {31'h0, v >= 32'h3 && v <= 32'h4}, 32'h1);
      rd(CTC_OFF_IRQ_ST, 32'h2, 32'h2);
      $display("test measure done");
      give_verdict();
   end
endmodule
